// ---- src/wwfc_consts.svh ----
// constants for the windowed watchdog fail counter block
// assumes a 10 MHz core clock and APB register access
`ifndef WWFC_CONSTS_SVH
`define WWFC_CONSTS_SVH
// register byte addresses
`define WWFC_ADDR_SAFETY_CFG 8'h00
`define WWFC_ADDR_CTRL 8'h04
`define WWFC_ADDR_WIN1 8'h08
`define WWFC_ADDR_WIN2 8'h0C
`define WWFC_ADDR_STATUS 8'h10
`define WWFC_ADDR_CMD 8'h14
// field positions
`define WWFC_BIT_RST_PERMIT 3
`define WWFC_BIT_DRV_PERMIT 0
`define WWFC_BIT_EXPIRY 1
`define WWFC_BIT_CMD_LOCK 0
`define WWFC_BIT_CMD_ACTIVE 1
// reset and load values
`define WWFC_TALLY_LOAD 3'h5
`define WWFC_TALLY_MAX 3'h7
`define WWFC_TALLY_OOR 3'h5
`define WWFC_WIN1_DEFAULT 7'h10
`define WWFC_WIN2_DEFAULT 5'h08
// timing: core clock 10 MHz, step 0.55 ms = 550000 ns
`define WWFC_CLK_NS 100
`define WWFC_STEP_NS 550000
`define WWFC_STEP_CYC (`WWFC_STEP_NS / `WWFC_CLK_NS)
// filter 32 us = 32000 ns, least time rounds up
`define WWFC_FILT_NS 32000
`define WWFC_FILT_CYC ((`WWFC_FILT_NS + `WWFC_CLK_NS - 1) / `WWFC_CLK_NS)
`endif

// ---- src/wwfc_pkg.sv ----
// types for the windowed watchdog fail counter block
// assumes wwfc_consts.svh holds the address, field, tally and timing constants
package wwfc_pkg;
   // device states, gray along reset -> diag -> active
   typedef enum logic [1:0] {
      WWFC_ST_RESET = 2'b00,
      WWFC_ST_DIAG = 2'b01,
      WWFC_ST_ACTIVE = 2'b11
   } wwfc_dev_e;
   // watchdog window phase
   typedef enum logic [1:0] {
      WWFC_WIN_ONE = 2'b00,
      WWFC_WIN_TWO = 2'b01
   } wwfc_win_e;
endpackage : wwfc_pkg

// ---- src/wwfc_watchdog.sv ----
// windowed watchdog with trigger filter, fail tally and apb registers
// assumes a 10 MHz clock, apb master on same clock, async trigger and cs pins
//
// Behaviour
// [R1] good event decrements tally, floor zero
// [R2] bad event increments tally, ceiling seven
// [R3] time-out increments tally, sets expiry flag
// [R4] tally five or more forces enable low
// [R5] tally four or less: enable follows permit
// [R6] tally ignores reset-permit bit
// [R7] load five entering diag and active
// [R8] bad event at seven with permit resets
// [R9] permit set at seven resets at once
// [R10] sequence is window one then two
// [R11] window one from 7-bit step count
// [R12] window two lasts field plus one steps
// [R13] step tick from divided system clock
// [R14] locked diag ignores window value writes
// [R15] window write restarts sequence, bumps tally
// [R16] time-out after both windows, restart
// [R17] trigger mode default after reset
// [R18] trigger pulse must exceed 32 us
// [R19] trigger in window one is bad
// [R20] trigger in window two is good
// [R21] time-out during spi frame: no flag
// [R22] mcu triggers early enough in window two
// [R23] watchdog failure overrides drive permit
// [R24] filter needs full stable filter time
`timescale 1ns/10ps
`include "wwfc_consts.svh"
`default_nettype none
module wwfc_watchdog (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_trigger_input_pin,
   input wire logic i_spi_cs_n,
   input wire logic i_other_error,
   output logic o_power_stage_enable_out,
   output logic o_mcu_reset_out_n
);
   localparam int STEP_CYC = `WWFC_STEP_CYC;
   localparam int FILT_CYC = `WWFC_FILT_CYC;

   typedef struct packed {
      logic [1:0] trg_sync;
      logic [1:0] cs_sync;
      logic trg_filt;
      logic [8:0] filt_cnt;
      logic trg_high;
      logic [12:0] div_cnt;
      logic [6:0] step_cnt;
      wwfc_pkg::wwfc_win_e win;
      wwfc_pkg::wwfc_dev_e dev;
      logic [2:0] tally;
      logic [6:0] win1_len;
      logic [4:0] win2_len;
      logic locked;
      logic rst_permit;
      logic drv_permit;
      logic expiry;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic enable_out;
      logic mcu_rst_n;
   } wwfc_state_s;

   wwfc_state_s s_q;
   wwfc_state_s s_d;

   // saturating tally step, shared by all event sources
   function automatic logic [2:0] tally_step(input logic [2:0] t, input logic up);
      if (up) begin
         tally_step = (t == `WWFC_TALLY_MAX) ? t : 3'(t + 3'h1);
      end else begin
         tally_step = (t == 3'h0) ? t : 3'(t - 3'h1);
      end
   endfunction : tally_step

   // decode of the mapped register offsets, judged in the setup phase
   function automatic logic addr_mapped(input logic [7:0] a);
      case (a)
         `WWFC_ADDR_SAFETY_CFG, `WWFC_ADDR_CTRL, `WWFC_ADDR_WIN1,
         `WWFC_ADDR_WIN2, `WWFC_ADDR_STATUS, `WWFC_ADDR_CMD: addr_mapped = 1'b1;
         default: addr_mapped = 1'b0;
      endcase
   endfunction : addr_mapped

   logic wr_acc;
   logic step_tick;
   logic trig_evt;
   logic win_wr;
   logic timeout;
   logic bad_evt;
   logic good_evt;
   logic [6:0] win_limit;
   logic permit_rise;
   logic wd_reset;

   // next-state logic for the whole block
   always_comb begin
      s_d = s_q;
      wr_acc = i_psel && i_penable && i_pwrite;
      win_wr = 1'b0;
      timeout = 1'b0;
      bad_evt = 1'b0;
      good_evt = 1'b0;

      // pin synchronisers, first stage read only by the second
      s_d.trg_sync = {s_q.trg_sync[0], i_trigger_input_pin};
      s_d.cs_sync = {s_q.cs_sync[0], i_spi_cs_n};

      // [R24] stable-level deglitch filter
      if (s_q.trg_sync[1] == s_q.trg_filt) begin
         s_d.filt_cnt = 9'h000;
      end else if (s_q.filt_cnt == 9'(FILT_CYC - 1)) begin
         s_d.filt_cnt = 9'h000;
         s_d.trg_filt = s_q.trg_sync[1];
      end else begin
         s_d.filt_cnt = 9'(s_q.filt_cnt + 9'h001);
      end
      // [R18] trigger counts on the filtered falling edge after a long high
      trig_evt = s_q.trg_high && !s_q.trg_filt;
      s_d.trg_high = s_q.trg_filt;
      if (trig_evt) begin
         s_d.trg_high = 1'b0;
      end

      // [R13] 0.55 ms step divider
      step_tick = (s_q.div_cnt == 13'(STEP_CYC - 1));
      s_d.div_cnt = step_tick ? 13'h0000 : 13'(s_q.div_cnt + 13'h0001);

      // register writes; pready is high in every access phase
      s_d.pready = i_psel && !i_penable;
      // error decided in setup so that it stands beside pready
      s_d.pslverr = i_psel && !i_penable && !addr_mapped(i_paddr);
      if (wr_acc && s_q.pready) begin
         case (i_paddr)
            `WWFC_ADDR_SAFETY_CFG: s_d.rst_permit = i_pwdata[`WWFC_BIT_RST_PERMIT];
            `WWFC_ADDR_CTRL: s_d.drv_permit = i_pwdata[`WWFC_BIT_DRV_PERMIT];
            `WWFC_ADDR_WIN1: begin
               win_wr = 1'b1;
               // [R14] locked diagnostic state keeps the old value
               if (!(s_q.locked && s_q.dev == wwfc_pkg::WWFC_ST_DIAG)) begin
                  s_d.win1_len = i_pwdata[6:0];
               end
            end
            `WWFC_ADDR_WIN2: begin
               win_wr = 1'b1;
               if (!(s_q.locked && s_q.dev == wwfc_pkg::WWFC_ST_DIAG)) begin
                  s_d.win2_len = i_pwdata[4:0];
               end
            end
            `WWFC_ADDR_STATUS: begin
               // write one to clear expiry
               if (i_pwdata[`WWFC_BIT_EXPIRY]) begin
                  s_d.expiry = 1'b0;
               end
            end
            `WWFC_ADDR_CMD: begin
               if (i_pwdata[`WWFC_BIT_CMD_LOCK]) begin
                  s_d.locked = 1'b1;
               end
               if (i_pwdata[`WWFC_BIT_CMD_ACTIVE] && s_q.dev == wwfc_pkg::WWFC_ST_DIAG) begin
                  s_d.dev = wwfc_pkg::WWFC_ST_ACTIVE;
                  // [R7] load on diag to active
                  s_d.tally = `WWFC_TALLY_LOAD;
               end
            end
            // unmapped: no effect, the error was flagged in setup
            default: ;
         endcase
      end

      // register reads
      s_d.prdata = 32'h0000_0000;
      if (i_psel && !i_penable && !i_pwrite) begin
         case (i_paddr)
            `WWFC_ADDR_SAFETY_CFG: s_d.prdata[`WWFC_BIT_RST_PERMIT] = s_q.rst_permit;
            `WWFC_ADDR_CTRL: s_d.prdata[`WWFC_BIT_DRV_PERMIT] = s_q.drv_permit;
            `WWFC_ADDR_WIN1: s_d.prdata[6:0] = s_q.win1_len;
            `WWFC_ADDR_WIN2: s_d.prdata[4:0] = s_q.win2_len;
            `WWFC_ADDR_STATUS: begin
               s_d.prdata[`WWFC_BIT_EXPIRY] = s_q.expiry;
               s_d.prdata[10:8] = s_q.tally;
               s_d.prdata[13:12] = s_q.dev;
               s_d.prdata[14] = s_q.locked;
            end
            default: s_d.prdata = 32'h0000_0000;
         endcase
      end
      // [R9] permit bit going from zero to one in this access
      permit_rise = !s_q.rst_permit && s_d.rst_permit;

      // [R10] window one then window two; [R11] [R12] lengths in steps
      win_limit = (s_q.win == wwfc_pkg::WWFC_WIN_ONE) ? s_q.win1_len
                  : 7'({2'b00, s_q.win2_len} + 7'h01);
      if (step_tick) begin
         // [R11] window one ends after field minus one step ticks
         if (s_q.win == wwfc_pkg::WWFC_WIN_ONE
             && 7'(s_q.step_cnt + 7'h02) >= s_q.win1_len) begin
            s_d.win = wwfc_pkg::WWFC_WIN_TWO;
            s_d.step_cnt = 7'h00;
         end else if (s_q.win == wwfc_pkg::WWFC_WIN_TWO
                      && 7'(s_q.step_cnt + 7'h01) >= win_limit) begin
            // [R16] time-out at end of window two
            timeout = 1'b1;
         end else begin
            s_d.step_cnt = 7'(s_q.step_cnt + 7'h01);
         end
      end
      // [R19] [R20] classify trigger by window
      if (trig_evt && s_q.dev != wwfc_pkg::WWFC_ST_RESET) begin
         if (s_q.win == wwfc_pkg::WWFC_WIN_ONE) begin
            bad_evt = 1'b1;
         end else begin
            good_evt = 1'b1;
         end
      end
      // [R15] window writes count as bad and restart
      if (win_wr) begin
         bad_evt = 1'b1;
      end
      if (timeout || bad_evt || good_evt) begin
         s_d.win = wwfc_pkg::WWFC_WIN_ONE;
         s_d.step_cnt = 7'h00;
      end

      // [R1] [R2] [R3] [R6] tally update, independent of permit bit
      if (s_q.dev != wwfc_pkg::WWFC_ST_RESET) begin
         if (timeout || bad_evt) begin
            s_d.tally = tally_step(s_q.tally, 1'b1);
         end else if (good_evt) begin
            s_d.tally = tally_step(s_q.tally, 1'b0);
         end
      end
      // [R3] [R21] expiry flag only outside an spi frame; set wins over clear
      if (timeout && s_q.cs_sync[1]) begin
         s_d.expiry = 1'b1;
      end

      // [R8] [R9] watchdog reset of the mcu
      // a rise to seven with the permit set waits for the next failure
      wd_reset = s_q.dev != wwfc_pkg::WWFC_ST_RESET && s_q.tally == `WWFC_TALLY_MAX
                 && ((s_q.rst_permit && (bad_evt || timeout)) || permit_rise);
      if (wd_reset) begin
         s_d.dev = wwfc_pkg::WWFC_ST_RESET;
         s_d.tally = `WWFC_TALLY_LOAD;
      end else if (s_q.dev == wwfc_pkg::WWFC_ST_RESET) begin
         // [R7] [R10] [R17] diag entry: load, defaults, trigger mode
         s_d.dev = wwfc_pkg::WWFC_ST_DIAG;
         s_d.tally = `WWFC_TALLY_LOAD;
         s_d.win1_len = `WWFC_WIN1_DEFAULT;
         s_d.win2_len = `WWFC_WIN2_DEFAULT;
         s_d.win = wwfc_pkg::WWFC_WIN_ONE;
         s_d.step_cnt = 7'h00;
         s_d.locked = 1'b0;
         // permit cleared so a fresh diag state never loops into reset
         s_d.rst_permit = 1'b0;
      end
      s_d.mcu_rst_n = (s_d.dev != wwfc_pkg::WWFC_ST_RESET);

      // [R4] [R5] [R23] enable output from tally, permit and other errors
      s_d.enable_out = (s_d.tally < `WWFC_TALLY_OOR) && s_d.drv_permit
                       && !i_other_error && (s_d.dev != wwfc_pkg::WWFC_ST_RESET);
   end

   // single state register, synchronous reset
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s_q <= '0;
         s_q.dev <= wwfc_pkg::WWFC_ST_RESET;
         s_q.tally <= `WWFC_TALLY_LOAD;
         s_q.win1_len <= `WWFC_WIN1_DEFAULT;
         s_q.win2_len <= `WWFC_WIN2_DEFAULT;
         s_q.cs_sync <= 2'b11;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign o_prdata = s_q.prdata;
   assign o_pready = s_q.pready;
   assign o_pslverr = s_q.pslverr;
   assign o_power_stage_enable_out = s_q.enable_out;
   assign o_mcu_reset_out_n = s_q.mcu_rst_n;

   // assertions
   a_oor_enable_low: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R4]
      s_q.tally >= `WWFC_TALLY_OOR |-> !o_power_stage_enable_out)
      else $error("enable high while tally out of range");
   a_good_decrement: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R1]
      good_evt && !bad_evt && !timeout && s_q.dev != wwfc_pkg::WWFC_ST_RESET && !wr_acc
      && s_q.tally != 3'h0 |=> s_q.tally == 3'($past(s_q.tally) - 3'h1))
      else $error("good event did not decrement tally");
   a_bad_saturate: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R2]
      bad_evt && s_q.tally == 3'h7 && !s_q.rst_permit && s_q.dev != wwfc_pkg::WWFC_ST_RESET
      && !(wr_acc && i_paddr != `WWFC_ADDR_WIN1 && i_paddr != `WWFC_ADDR_WIN2)
      |=> s_q.tally == 3'h7)
      else $error("tally beyond seven");
   a_expiry_set: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R3]
      timeout && s_q.cs_sync[1] |=> s_q.expiry)
      else $error("timeout did not set expiry");
   a_frame_no_flag: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R21]
      timeout && !s_q.cs_sync[1] && !s_q.expiry && !(wr_acc && s_q.pready)
      |=> !s_q.expiry)
      else $error("expiry set during spi frame");
   a_permit_reset: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R9]
      permit_rise && s_q.tally == 3'h7 && s_q.dev != wwfc_pkg::WWFC_ST_RESET
      |=> s_q.dev == wwfc_pkg::WWFC_ST_RESET && !o_mcu_reset_out_n)
      else $error("no reset with permit at seven");
   a_restart_window: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R15]
      win_wr |=> s_q.win == wwfc_pkg::WWFC_WIN_ONE && s_q.step_cnt == 7'h00)
      else $error("window write did not restart sequence");
   a_diag_load: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R7]
      s_q.dev == wwfc_pkg::WWFC_ST_RESET |=> s_q.tally == 3'h5)
      else $error("tally not loaded to five");
   a_window_one_bad: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R19]
      trig_evt && s_q.win == wwfc_pkg::WWFC_WIN_ONE && s_q.dev != wwfc_pkg::WWFC_ST_RESET
      && s_q.tally < 3'h7 && !timeout && !wr_acc
      |=> s_q.tally == 3'($past(s_q.tally) + 3'h1))
      else $error("trigger in window one not bad");
   c_good_event: cover property (@(posedge i_core_clk) disable iff (i_rst) good_evt);
   c_timeout: cover property (@(posedge i_core_clk) disable iff (i_rst) timeout);
   c_mcu_reset: cover property (@(posedge i_core_clk) disable iff (i_rst)
      $fell(o_mcu_reset_out_n));
   c_window_bad: cover property (@(posedge i_core_clk) disable iff (i_rst)
      trig_evt && bad_evt);

   // further checks on tally, enable, reset, window length, divider, bus and expiry
   // time-out alone bumps the tally and restarts the sequence
   a_timeout_count: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R16]
      timeout && !bad_evt && !good_evt && !wd_reset && !wr_acc
      && s_q.dev != wwfc_pkg::WWFC_ST_RESET && s_q.tally != 3'h7
      |=> s_q.tally == 3'($past(s_q.tally) + 3'h1) && s_q.win == wwfc_pkg::WWFC_WIN_ONE)
      else $error("time-out did not bump tally");
   // enable follows permit only while the tally is in range
   a_enable_follow: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R5]
      s_q.enable_out == (s_q.tally < `WWFC_TALLY_OOR && s_q.drv_permit
      && s_q.dev != wwfc_pkg::WWFC_ST_RESET && !$past(i_other_error)))
      else $error("enable does not follow permit");
   // failure at seven with the permit set resets the mcu
   a_fail_reset: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R8]
      bad_evt && s_q.rst_permit && s_q.tally == 3'h7 && s_q.dev != wwfc_pkg::WWFC_ST_RESET
      |=> s_q.dev == wwfc_pkg::WWFC_ST_RESET && !o_mcu_reset_out_n && s_q.tally == 3'h5)
      else $error("no reset on failure at seven");
   // locked diag state keeps the window length
   a_win_lock: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R14]
      wr_acc && s_q.pready && i_paddr == `WWFC_ADDR_WIN1 && s_q.locked
      && s_q.dev == wwfc_pkg::WWFC_ST_DIAG |=> s_q.win1_len == $past(s_q.win1_len))
      else $error("locked window length changed");
   // divider wraps after the tick
   a_step_tick: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R13]
      step_tick |=> s_q.div_cnt == 13'h0000)
      else $error("step divider did not wrap");
   // bus error only ever beside ready
   a_error_pair: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_pslverr |-> o_pready)
      else $error("slave error without ready");
   // write one clears expiry when no time-out competes
   a_expiry_clear: assert property (@(posedge i_core_clk) disable iff (i_rst) // [R3]
      wr_acc && s_q.pready && i_paddr == `WWFC_ADDR_STATUS
      && i_pwdata[`WWFC_BIT_EXPIRY] && !timeout |=> !s_q.expiry)
      else $error("expiry not cleared");
endmodule : wwfc_watchdog
`default_nettype wire

// ---- verification/wwfc_mcu_model.sv ----
// mcu stand-in: drives the watchdog trigger pin and the spi frame marker
// assumes its tasks are called just after a rising edge of the core clock
`timescale 1ns/10ps
`default_nettype none
module wwfc_mcu_model (
   input wire logic i_core_clk,
   output logic o_trigger,
   output logic o_cs_n
);
   // idle levels: no pulse, no spi frame open
   initial begin
      o_trigger = 1'b0;
      o_cs_n = 1'b1;
   end
   // hold each pulse above the filter time
   // caller picks the high time, must stay above the filter time
   task automatic pulse(input int hi);
      o_trigger <= 1'b1;
      repeat (hi) @(posedge i_core_clk);
      o_trigger <= 1'b0;
   endtask : pulse
   // chip select low while a frame is open
   task automatic frame(input logic open);
      o_cs_n <= ~open;
   endtask : frame
endmodule : wwfc_mcu_model
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the windowed watchdog fail counter
// assumes window lengths are shortened over apb so the run stays short
`timescale 1ns/10ps
`include "wwfc_consts.svh"
`default_nettype none
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module testbench;
   logic clk, rst, psel, penable, pwrite, other_err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, trig, cs_n, en_out, mcu_rst_n, err;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n_rst_pulse = 0;

   wwfc_watchdog i_dut (
      .i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_trigger_input_pin(trig),
      .i_spi_cs_n(cs_n), .i_other_error(other_err),
      .o_power_stage_enable_out(en_out), .o_mcu_reset_out_n(mcu_rst_n)
   );
   wwfc_mcu_model i_mcu (.i_core_clk(clk), .o_trigger(trig), .o_cs_n(cs_n));

   // 10 MHz core clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic close_out();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   // hang guard, well above the roughly 62k cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         n_mismatch++;
         close_out();
      end
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_cyc

   // one apb transfer: access held until pready is sampled high at a rising
   // edge; an idle cycle follows so the next setup never reuses this step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      `CHECK(pready, 1'b1)
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // low cycles of the mcu reset output after start-up
   always @(posedge clk) begin
      if (!rst && mcu_rst_n === 1'b0) n_rst_pulse <= n_rst_pulse + 1;
   end

   // pulse of 400 cycles after a lead, then room for filter and sync
   // a lead of 5800 puts the rising edge well inside window two
   task automatic trig_event(input int lead);
      wait_cyc(lead);
      i_mcu.pulse(400);
      wait_cyc(340);
   endtask : trig_event

   task automatic t_after_reset();
      apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
      `CHECK(rd[10:8], 3'h5)
      `CHECK(rd[13:12], 2'h1)
      `CHECK(err, 1'b0)
      `CHECK(en_out, 1'b0)
      `CHECK(mcu_rst_n, 1'b1)
      apb(1'b0, `WWFC_ADDR_WIN1, 32'h0);
      `CHECK(rd[6:0], `WWFC_WIN1_DEFAULT)
      apb(1'b0, 8'h3C, 32'h0);
      `CHECK(err, 1'b1)
   endtask : t_after_reset

   // window one one step, window two two steps; lock then rewrite
   task automatic t_windows();
      apb(1'b1, `WWFC_ADDR_WIN1, 32'h2);
      apb(1'b1, `WWFC_ADDR_WIN2, 32'h1);
      apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
      `CHECK(rd[10:8], 3'h7)
      apb(1'b1, `WWFC_ADDR_CMD, 32'h1);
      apb(1'b1, `WWFC_ADDR_WIN1, 32'h7F);
      apb(1'b0, `WWFC_ADDR_WIN1, 32'h0);
      `CHECK(rd[6:0], 7'h02)
      apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
      `CHECK(rd[10:8], 3'h7)
   endtask : t_windows

   // three triggers in window two walk the tally down to four
   task automatic t_good();
      apb(1'b1, `WWFC_ADDR_CTRL, 32'h1);
      for (int k = 6; k >= 4; k--) begin
         trig_event(5800);
         apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
         `CHECK(rd[10:8], 3'(k))
      end
      wait_cyc(2);
      `CHECK(en_out, 1'b1)
      other_err <= 1'b1;
      wait_cyc(3);
      `CHECK(en_out, 1'b0)
      other_err <= 1'b0;
      wait_cyc(3);
      `CHECK(en_out, 1'b1)
   endtask : t_good

   // go active, stretch window one to two steps, trigger inside it
   task automatic t_bad();
      apb(1'b1, `WWFC_ADDR_CMD, 32'h2);
      apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
      `CHECK(rd[10:8], 3'h5)
      `CHECK(rd[13:12], 2'h3)
      `CHECK(en_out, 1'b0)
      apb(1'b1, `WWFC_ADDR_WIN1, 32'h3);
      trig_event(0);
      apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
      `CHECK(rd[10:8], 3'h7)
      apb(1'b0, `WWFC_ADDR_WIN1, 32'h0);
      `CHECK(rd[6:0], 7'h03)
   endtask : t_bad

   // a good event, then one time-out inside a frame and one outside
   task automatic t_timeout();
      apb(1'b1, `WWFC_ADDR_WIN1, 32'h2);
      trig_event(5800);
      apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
      `CHECK(rd[10:8], 3'h6)
      i_mcu.frame(1'b1);
      wait_cyc(17000);
      i_mcu.frame(1'b0);
      apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
      `CHECK(rd[10:8], 3'h7)
      `CHECK(rd[1], 1'b0)
      wait_cyc(17000);
      apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
      `CHECK(rd[10:8], 3'h7)
      `CHECK(rd[1], 1'b1)
   endtask : t_timeout

   // failures at seven leave the tally there while the permit is clear
   task automatic t_saturate();
      int n0;
      n0 = n_rst_pulse;
      apb(1'b1, `WWFC_ADDR_WIN1, 32'h3);
      trig_event(0);
      apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
      `CHECK(rd[10:8], 3'h7)
      `CHECK(n_rst_pulse, n0)
      apb(1'b1, `WWFC_ADDR_STATUS, 32'h2);
      apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
      `CHECK(rd[1], 1'b0)
   endtask : t_saturate

   // permit set at seven resets at once; later a failure at seven resets
   task automatic t_permit();
      int n0;
      n0 = n_rst_pulse;
      apb(1'b1, `WWFC_ADDR_SAFETY_CFG, 32'h8);
      wait_cyc(3);
      `CHECK(n_rst_pulse, n0 + 1)
      apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
      `CHECK(rd[10:8], 3'h5)
      `CHECK(rd[13:12], 2'h1)
      apb(1'b1, `WWFC_ADDR_SAFETY_CFG, 32'h8);
      apb(1'b1, `WWFC_ADDR_WIN2, 32'h8);
      apb(1'b1, `WWFC_ADDR_WIN2, 32'h8);
      apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
      `CHECK(rd[10:8], 3'h7)
      `CHECK(n_rst_pulse, n0 + 1)
      apb(1'b1, `WWFC_ADDR_WIN2, 32'h8);
      wait_cyc(3);
      `CHECK(n_rst_pulse, n0 + 2)
      apb(1'b0, `WWFC_ADDR_STATUS, 32'h0);
      `CHECK(rd[10:8], 3'h5)
   endtask : t_permit

   // main sequence
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      other_err = 1'b0;
      wait_cyc(6);
      rst <= 1'b0;
      wait_cyc(2);
      t_after_reset();
      t_windows();
      t_good();
      t_bad();
      t_timeout();
      t_saturate();
      t_permit();
      close_out();
   end
endmodule : testbench
`default_nettype wire
